// >>> design/vectored_interrupt_controller.sv
// vectored interrupt controller: flags, edge select, arbiter, acceptance
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller #(
  parameter int VEC_W = 16
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [15:0] sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  input  wire logic [7:0]  psw_wdata,
  input  wire logic        psw_wr,
  output logic      [7:0]  psw_out,
  input  wire logic [6:0]  ext_irq_pin,
  input  wire logic        wdt_overflow,
  input  wire logic        wdt_nmi_mode,
  input  wire logic [11:0] periph_req,
  input  wire logic [2:0]  cpu_clock_divider_bit,
  input  wire logic        halt,
  input  wire logic        instr_done,
  input  wire logic        return_from_interrupt_instr,
  input  wire logic [15:0] pc_now,
  output logic             irq_pending,
  output logic             push_valid,
  output logic      [7:0]  push_data,
  output logic             pc_load,
  output logic      [15:0] pc_load_addr,
  output logic             win_valid,
  output logic      [4:0]  win_index,
  output logic      [15:0] win_vector,
  output logic             standby_release
);
  localparam int NS = intc_pkg::NUM_SRC;

  logic [23:0]   req_r;
  logic [23:0]   req_nxt;
  logic [23:0]   mask_r;
  logic [23:0]   mask_nxt;
  logic [23:0]   prio_r;
  logic [23:0]   prio_nxt;
  logic [7:0]    edge_lo_r;
  logic [7:0]    edge_up_r;
  logic [7:0]    samp_sel_r;
  logic [7:0]    psw_r;
  logic [7:0]    saved_psw_r;
  logic [15:0]   saved_pc_r;
  logic [15:0]   vec_r;
  logic [7:0]    push_data_r;
  logic [7:0]    rdata_r;
  logic [6:0]    cnt_r;
  logic          nmi_pend_r;
  logic          nmi_busy_r;
  intc_pkg::seq_state_type state_r;
  logic [NS-1:0] set_vec;
  logic [NS-1:0] elig;
  logic [NS-1:0] hi_grp;
  logic [NS-1:0] pool;
  logic [4:0]    win_idx;
  logic          win_any;
  logic          mask_ok;
  logic          nmi_ok;
  logic          boundary;
  logic          take_nmi;
  logic          take_mask;
  logic          cpu_tick;
  logic          pin0_tick;
  logic [6:0]    pin_hit;
  logic [13:0]   edge_modes;
  logic [23:0]   clr24;
  logic [23:0]   set24;

  if (VEC_W < 7 || VEC_W > 16) begin : g_bad_vec_w
    $error("VEC_W must lie in 7..16");
  end

  // prescaler runs on the system clock; the CPU option stops in HALT
  always_ff @(posedge mclk) begin
    if (reset) cnt_r <= 7'h00;
    else cnt_r <= cnt_r + 7'h01;
  end

  always_comb begin
    case (cpu_clock_divider_bit)
      3'h0:    cpu_tick = 1'b1;
      3'h1:    cpu_tick = cnt_r[0];
      3'h2:    cpu_tick = &cnt_r[1:0];
      3'h3:    cpu_tick = &cnt_r[2:0];
      default: cpu_tick = &cnt_r[3:0]; // codes above 4 act as 4
    endcase
    case (samp_sel_r[1:0])
      intc_pkg::SAMP_CPU:  pin0_tick = cpu_tick & ~halt;
      intc_pkg::SAMP_DIV5: pin0_tick = &cnt_r[4:0];
      intc_pkg::SAMP_DIV6: pin0_tick = &cnt_r[5:0];
      default:            pin0_tick = &cnt_r[6:0];
    endcase
  end

  // pin 0..2 fields in the lower edge register, 3..6 in the upper one
  assign edge_modes = {edge_up_r, edge_lo_r[7:2]};

  genvar g;
  generate
    for (g = 0; g < intc_pkg::PIN_COUNT; g++) begin : gen_pin
      pin_edge_detect #(
        .FILTER (g == 0)
      ) u_det (
        .mclk        (mclk),
        .reset       (reset),
        .pin         (ext_irq_pin[g]),
        .sample_tick ((g == 0) ? pin0_tick : 1'b1),
        .edge_mode   (edge_modes[2*g +: 2]),
        .hit         (pin_hit[g])
      );
    end
  endgenerate

  // watchdog feeds the flag only as an interval timer
  assign set_vec = {periph_req, pin_hit, wdt_overflow & ~wdt_nmi_mode};

  // combinational arbiter, lowest index wins inside the chosen group
  always_comb begin
    elig    = req_r[NS-1:0] & ~mask_r[NS-1:0];
    hi_grp  = elig & ~prio_r[NS-1:0];
    pool    = (|hi_grp) ? hi_grp : elig;
    win_idx = 5'h00;
    for (int i = NS - 1; i >= 0; i--) begin
      if (pool[i]) win_idx = 5'(i);
    end
    win_any = |elig;
  end

  // low group is refused while a high-priority handler runs
  assign mask_ok  = win_any & psw_r[intc_pkg::PSW_EN_BIT] & ~nmi_busy_r
                    & (~prio_r[win_idx]
                       | psw_r[intc_pkg::PSW_SERV_BIT]);
  assign nmi_ok   = nmi_pend_r & ~nmi_busy_r;
  // the return itself holds acceptance off for one more instruction
  assign boundary = instr_done & ~return_from_interrupt_instr
                    & (state_r == intc_pkg::SEQ_IDLE);
  assign take_nmi  = boundary & nmi_ok;
  assign take_mask = boundary & ~nmi_ok & mask_ok;
  assign irq_pending = nmi_ok | mask_ok;
  assign standby_release = (|elig) | nmi_pend_r;

  always_comb begin
    clr24 = 24'h000000;
    set24 = {4'h0, set_vec};
    if (take_mask) clr24[win_idx] = 1'b1;
    req_nxt  = req_r;
    mask_nxt = mask_r;
    prio_nxt = prio_r;
    if (sfr_wr) begin
      case (sfr_addr)
        intc_pkg::ADDR_REQ_LOW:  req_nxt[7:0]   = sfr_wdata;
        intc_pkg::ADDR_REQ_MID:  req_nxt[15:8]  = sfr_wdata;
        intc_pkg::ADDR_REQ_UP:   req_nxt[23:16] = sfr_wdata;
        intc_pkg::ADDR_MASK_LOW: mask_nxt[7:0]  = sfr_wdata;
        intc_pkg::ADDR_MASK_MID: mask_nxt[15:8] = sfr_wdata;
        intc_pkg::ADDR_MASK_UP:  mask_nxt[23:16] = sfr_wdata;
        intc_pkg::ADDR_PRIO_LOW: prio_nxt[7:0]  = sfr_wdata;
        intc_pkg::ADDR_PRIO_MID: prio_nxt[15:8] = sfr_wdata;
        intc_pkg::ADDR_PRIO_UP:  prio_nxt[23:16] = sfr_wdata;
        default: ;
      endcase
    end
    // a hardware set in the clearing cycle survives
    req_nxt = (req_nxt & ~clr24) | set24;
  end

  always_ff @(posedge mclk) begin
    if (reset) req_r <= {3{intc_pkg::REQ_RESET}};
    else req_r <= req_nxt;
  end

  always_ff @(posedge mclk) begin
    if (reset) mask_r <= {3{intc_pkg::MASK_RESET}};
    else mask_r <= mask_nxt;
  end

  always_ff @(posedge mclk) begin
    if (reset) prio_r <= {3{intc_pkg::PRIO_RESET}};
    else prio_r <= prio_nxt;
  end

  // byte writes only
  always_ff @(posedge mclk) begin
    if (reset) begin
      edge_lo_r  <= intc_pkg::EDGE_RESET;
      edge_up_r  <= intc_pkg::EDGE_RESET;
      samp_sel_r <= intc_pkg::SAMPLE_RESET;
    end else if (sfr_wr) begin
      if (sfr_addr == intc_pkg::ADDR_EDGE_LO) edge_lo_r <= sfr_wdata;
      if (sfr_addr == intc_pkg::ADDR_EDGE_UP) edge_up_r <= sfr_wdata;
      if (sfr_addr == intc_pkg::ADDR_SAMPLE) samp_sel_r <= sfr_wdata;
    end
  end

  // mask bits read as stored, also in watchdog non-maskable mode
  always_ff @(posedge mclk) begin
    if (reset) rdata_r <= 8'h00;
    else if (sfr_rd) begin
      case (sfr_addr)
        intc_pkg::ADDR_REQ_LOW:  rdata_r <= req_r[7:0];
        intc_pkg::ADDR_REQ_MID:  rdata_r <= req_r[15:8];
        intc_pkg::ADDR_REQ_UP:   rdata_r <= req_r[23:16];
        intc_pkg::ADDR_MASK_LOW: rdata_r <= mask_r[7:0];
        intc_pkg::ADDR_MASK_MID: rdata_r <= mask_r[15:8];
        intc_pkg::ADDR_MASK_UP:  rdata_r <= mask_r[23:16];
        intc_pkg::ADDR_PRIO_LOW: rdata_r <= prio_r[7:0];
        intc_pkg::ADDR_PRIO_MID: rdata_r <= prio_r[15:8];
        intc_pkg::ADDR_PRIO_UP:  rdata_r <= prio_r[23:16];
        intc_pkg::ADDR_EDGE_LO:  rdata_r <= edge_lo_r;
        intc_pkg::ADDR_EDGE_UP:  rdata_r <= edge_up_r;
        intc_pkg::ADDR_SAMPLE:   rdata_r <= samp_sel_r;
        default:                 rdata_r <= 8'h00;
      endcase
    end
  end

  // several arrivals during service collapse into one pending request
  always_ff @(posedge mclk) begin
    if (reset) nmi_pend_r <= 1'b0;
    else if (wdt_overflow && wdt_nmi_mode) nmi_pend_r <= 1'b1;
    else if (take_nmi) nmi_pend_r <= 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (reset) nmi_busy_r <= 1'b0;
    else if (take_nmi) nmi_busy_r <= 1'b1;
    else if (instr_done && return_from_interrupt_instr)
      nmi_busy_r <= 1'b0;
  end

  // status word; the core restores it by writing the popped byte
  always_ff @(posedge mclk) begin
    if (reset) psw_r <= intc_pkg::PSW_RESET;
    else if (take_nmi) begin
      psw_r[intc_pkg::PSW_EN_BIT]   <= 1'b0;
      psw_r[intc_pkg::PSW_SERV_BIT] <= 1'b0;
    end else if (take_mask) begin
      psw_r[intc_pkg::PSW_EN_BIT]   <= 1'b0;
      psw_r[intc_pkg::PSW_SERV_BIT] <= prio_r[win_idx];
    end else if (psw_wr) psw_r <= psw_wdata;
  end

  // snapshot before the bits change, so the pushed byte is the old one
  always_ff @(posedge mclk) begin
    if (reset) begin
      saved_psw_r <= 8'h00;
      saved_pc_r  <= 16'h0000;
      vec_r       <= 16'h0000;
    end else if (take_nmi || take_mask) begin
      saved_psw_r <= psw_r;
      saved_pc_r  <= pc_now;
      vec_r       <= take_nmi ? intc_pkg::VEC_NMI : win_vector;
    end
  end

  // entry sequence: status, PC high, PC low, then the jump
  always_ff @(posedge mclk) begin
    if (reset) state_r <= intc_pkg::SEQ_IDLE;
    else begin
      case (state_r)
        intc_pkg::SEQ_IDLE:
          if (take_nmi || take_mask) state_r <= intc_pkg::SEQ_PSW;
        intc_pkg::SEQ_PSW:  state_r <= intc_pkg::SEQ_PCH;
        intc_pkg::SEQ_PCH:  state_r <= intc_pkg::SEQ_PCL;
        intc_pkg::SEQ_PCL:  state_r <= intc_pkg::SEQ_JUMP;
        intc_pkg::SEQ_JUMP: state_r <= intc_pkg::SEQ_IDLE;
        default:            state_r <= intc_pkg::SEQ_IDLE;
      endcase
    end
  end

  always_comb begin
    case (state_r)
      intc_pkg::SEQ_PSW: push_data_r = saved_psw_r;
      intc_pkg::SEQ_PCH: push_data_r = saved_pc_r[15:8];
      intc_pkg::SEQ_PCL: push_data_r = saved_pc_r[7:0];
      default:           push_data_r = 8'h00;
    endcase
  end

  // win_valid and win_index come from flip-flops, one cycle behind the arbiter; win_vector is combinational
  always_ff @(posedge mclk) begin
    if (reset) begin
      win_valid <= 1'b0;
      win_index <= 5'h00;
    end else begin
      win_valid <= win_any;
      win_index <= win_idx;
    end
  end

  assign win_vector   = intc_pkg::VEC_BASE + {10'h000, win_idx, 1'b0};
  assign push_valid   = (state_r == intc_pkg::SEQ_PSW)
                        | (state_r == intc_pkg::SEQ_PCH)
                        | (state_r == intc_pkg::SEQ_PCL);
  assign push_data    = push_data_r;
  assign pc_load      = (state_r == intc_pkg::SEQ_JUMP);
  assign pc_load_addr = vec_r;
  assign psw_out      = psw_r;
  assign sfr_rdata    = rdata_r;

  a_mask_gate: assert property (@(posedge mclk) disable iff (reset)
    take_mask |-> req_r[win_idx] && !mask_r[win_idx]
                  && psw_r[intc_pkg::PSW_EN_BIT])
    else $error("maskable taken while masked, idle or disabled");
  a_nmi_first: assert property (@(posedge mclk) disable iff (reset)
    (boundary && nmi_pend_r && !nmi_busy_r) |-> !take_mask
      ##1 push_valid ##3 pc_load && pc_load_addr == intc_pkg::VEC_NMI)
    else $error("non-maskable request lost its precedence");
  a_low_held: assert property (@(posedge mclk) disable iff (reset)
    (take_mask && !psw_r[intc_pkg::PSW_SERV_BIT]) |-> !prio_r[win_idx])
    else $error("low group taken during high-priority service");
  a_inserv_copy: assert property (@(posedge mclk) disable iff (reset)
    take_mask |=> psw_r[intc_pkg::PSW_SERV_BIT] == $past(prio_r[win_idx])
                  && !psw_r[intc_pkg::PSW_EN_BIT])
    else $error("in-service bit not copied from winner");
  a_nmi_bits: assert property (@(posedge mclk) disable iff (reset)
    take_nmi |=> !psw_r[intc_pkg::PSW_EN_BIT]
                 && !psw_r[intc_pkg::PSW_SERV_BIT]
                 ##3 pc_load && pc_load_addr == intc_pkg::VEC_NMI)
    else $error("non-maskable entry state wrong");
  a_push_order: assert property (@(posedge mclk) disable iff (reset)
    (take_nmi || take_mask) |=> push_valid && push_data == $past(psw_r)
      ##1 push_valid && push_data == $past(pc_now[15:8], 2)
      ##1 push_valid ##1 pc_load && !push_valid)
    else $error("entry push order broken");
  a_flag_clear: assert property (@(posedge mclk) disable iff (reset)
    (take_mask && !set_vec[win_idx]) |=> !req_r[$past(win_idx)])
    else $error("acknowledged request flag left set");
  a_nmi_hold: assert property (@(posedge mclk) disable iff (reset)
    (nmi_busy_r && instr_done && return_from_interrupt_instr) |-> !take_nmi
      ##1 !nmi_busy_r)
    else $error("non-maskable request taken at its return");
  a_reset_vals: assert property (@(posedge mclk)
    $fell(reset) |-> mask_r == 24'hFFFFFF && prio_r == 24'hFFFFFF
                     && psw_r == 8'h02 && edge_up_r == 8'h00)
    else $error("reset values wrong");
  a_halt_stop: assert property (@(posedge mclk) disable iff (reset)
    (halt && samp_sel_r[1:0] == intc_pkg::SAMP_CPU) |-> !pin0_tick)
    else $error("cpu sampling clock runs in halt");
endmodule : vectored_interrupt_controller
`default_nettype wire

// >>> design/intc_pkg.sv
// constants and types shared by the interrupt controller files
package intc_pkg;
  localparam int          NUM_SRC       = 20;
  localparam int          PIN_COUNT     = 7;
  localparam logic [15:0] ADDR_REQ_LOW  = 16'hFFE0;
  localparam logic [15:0] ADDR_REQ_MID  = 16'hFFE1;
  localparam logic [15:0] ADDR_REQ_UP   = 16'hFFE2;
  localparam logic [15:0] ADDR_MASK_LOW = 16'hFFE4;
  localparam logic [15:0] ADDR_MASK_MID = 16'hFFE5;
  localparam logic [15:0] ADDR_MASK_UP  = 16'hFFE6;
  localparam logic [15:0] ADDR_PRIO_LOW = 16'hFFE8;
  localparam logic [15:0] ADDR_PRIO_MID = 16'hFFE9;
  localparam logic [15:0] ADDR_PRIO_UP  = 16'hFFEA;
  localparam logic [15:0] ADDR_EDGE_LO  = 16'hFFEC;
  localparam logic [15:0] ADDR_EDGE_UP  = 16'hFFED;
  localparam logic [15:0] ADDR_SAMPLE   = 16'hFFEF;
  localparam logic [7:0]  REQ_RESET     = 8'h00;
  localparam logic [7:0]  MASK_RESET    = 8'hFF;
  localparam logic [7:0]  PRIO_RESET    = 8'hFF;
  localparam logic [7:0]  EDGE_RESET    = 8'h00;
  localparam logic [7:0]  SAMPLE_RESET  = 8'h00;
  localparam logic [7:0]  PSW_RESET     = 8'h02;
  localparam int          PSW_EN_BIT    = 7;
  localparam int          PSW_SERV_BIT  = 1;
  localparam int          WDT_SRC       = 0;
  localparam logic [15:0] VEC_NMI       = 16'h0004;
  localparam logic [15:0] VEC_BASE      = 16'h0004;
  localparam logic [1:0]  EDGE_FALL     = 2'h0;
  localparam logic [1:0]  EDGE_RISE     = 2'h1;
  localparam logic [1:0]  EDGE_BOTH     = 2'h3;
  localparam logic [1:0]  SAMP_CPU      = 2'h0;
  localparam logic [1:0]  SAMP_DIV5     = 2'h1;
  localparam logic [1:0]  SAMP_DIV6     = 2'h2;
  localparam logic [1:0]  SAMP_DIV7     = 2'h3;
  localparam logic [2:0]  CPU_DIV_MAX   = 3'h4;
  localparam int          SEQ_CYCLES    = 4;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_PSW  = 3'h1,
    SEQ_PCH  = 3'h3,
    SEQ_PCL  = 3'h2,
    SEQ_JUMP = 3'h6
  } seq_state_type;
endpackage : intc_pkg

// >>> design/pin_edge_detect.sv
// valid-edge detector for one interrupt pin, with optional noise remover
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect #(
  parameter bit FILTER = 1'b0
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       pin,
  input  wire logic       sample_tick,
  input  wire logic [1:0] edge_mode,
  output logic            hit
);
  logic samp_r;
  logic level_r;
  logic prev_r;

  // with FILTER set, level only moves after two equal samples in a row
  always_ff @(posedge mclk) begin
    if (reset) begin
      samp_r  <= 1'b0;
      level_r <= 1'b0;
    end else if (sample_tick) begin
      samp_r <= pin;
      if (!FILTER || samp_r == pin) level_r <= pin;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) prev_r <= 1'b0;
    else prev_r <= level_r;
  end

  always_comb begin
    case (edge_mode)
      intc_pkg::EDGE_FALL: hit = prev_r & ~level_r;
      intc_pkg::EDGE_RISE: hit = ~prev_r & level_r;
      intc_pkg::EDGE_BOTH: hit = prev_r ^ level_r;
      default:             hit = 1'b0; // prohibited code detects nothing
    endcase
  end

  a_filter_two_samp: assert property (@(posedge mclk) disable iff (reset)
    (FILTER && $rose(level_r)) |-> $past(samp_r))
    else $error("filtered level rose after a single sample");
endmodule : pin_edge_detect
`default_nettype wire

// >>> bench/cpu_core_model.sv
// core stand-in: instruction pacing, stack capture and return handling
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [3:0]  gap,
  input  wire logic        return_from_interrupt_instr_go,
  input  wire logic        bench_psw_wr,
  input  wire logic [7:0]  bench_psw_wdata,
  input  wire logic        push_valid,
  input  wire logic [7:0]  push_data,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_load_addr,
  output logic             instr_done,
  output logic             return_from_interrupt_instr,
  output logic             psw_wr,
  output logic      [7:0]  psw_wdata,
  output logic      [15:0] pc_now,
  output logic      [7:0]  saved_psw,
  output logic      [7:0]  entries,
  output logic      [15:0] vec_taken
);
  logic [3:0] cnt_r;
  logic       return_from_interrupt_instr_r;
  logic [1:0] idx_r;
  logic       busy;

  // the entry sequence owns the core, so no completion while it runs
  assign busy = push_valid | pc_load;
  assign instr_done = !reset && cnt_r == 4'h0 && !busy;
  assign return_from_interrupt_instr = instr_done & return_from_interrupt_instr_r;
  // a return reloads the stacked status word
  assign psw_wr = bench_psw_wr | return_from_interrupt_instr;
  assign psw_wdata = return_from_interrupt_instr ? saved_psw : bench_psw_wdata;

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r <= 4'h0;
      return_from_interrupt_instr_r <= 1'b0;
    end else begin
      if (return_from_interrupt_instr_go)
        return_from_interrupt_instr_r <= 1'b1;
      else if (return_from_interrupt_instr)
        return_from_interrupt_instr_r <= 1'b0;
      if (instr_done)
        cnt_r <= gap;
      else if (cnt_r != 4'h0 && !busy)
        cnt_r <= cnt_r - 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      idx_r <= 2'h0;
      entries <= 8'h00;
      pc_now <= 16'h0100;
      saved_psw <= 8'h00;
      vec_taken <= 16'h0000;
    end else begin
      if (instr_done)
        pc_now <= pc_now + 16'h0001;
      if (push_valid) begin
        idx_r <= idx_r + 2'h1;
        // first byte of each entry is the status word
        if (idx_r == 2'h0)
          saved_psw <= push_data;
      end
      if (pc_load) begin
        idx_r <= 2'h0;
        entries <= entries + 8'h01;
        vec_taken <= pc_load_addr;
        pc_now <= pc_load_addr;
      end
    end
  end
endmodule : cpu_core_model
`default_nettype wire

// >>> bench/vectored_interrupt_controller_bench.sv
// bench for the interrupt controller with a core stand-in
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_controller_bench;
  // edge codes in test order: fall, rise, both, prohibited
  localparam logic [7:0] CODES = 8'hB4;
  localparam logic [3:0] RISE_HIT = 4'h6;
  localparam logic [3:0] FALL_HIT = 4'h5;
  logic        mclk, reset, sfr_wr, sfr_rd, psw_wr, wdt_overflow;
  logic        wdt_nmi_mode, halt, instr_done, return_from_interrupt_instr;
  logic        irq_pending, push_valid, pc_load, win_valid, standby_release;
  logic        return_from_interrupt_instr_go, bench_psw_wr;
  logic [15:0] sfr_addr, pc_now, pc_load_addr, win_vector, vec_taken;
  logic [7:0]  sfr_wdata, sfr_rdata, psw_wdata, psw_out, push_data;
  logic [7:0]  bench_psw_wdata, saved_psw, entries;
  logic [6:0]  ext_irq_pin;
  logic [11:0] periph_req;
  logic [4:0]  win_index;
  logic [3:0]  gap;
  logic [2:0]  cpu_clock_divider_bit;
  int          n_mismatch, checks_done;

  vectored_interrupt_controller u_vectored_interrupt_controller (
    .mclk, .reset, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
    .psw_wdata, .psw_wr, .psw_out, .ext_irq_pin, .wdt_overflow,
    .wdt_nmi_mode, .periph_req, .cpu_clock_divider_bit, .halt, .instr_done,
    .return_from_interrupt_instr, .pc_now, .irq_pending, .push_valid,
    .push_data, .pc_load, .pc_load_addr, .win_valid, .win_index,
    .win_vector, .standby_release
  );
  cpu_core_model u_cpu_core_model (
    .mclk, .reset, .gap, .return_from_interrupt_instr_go, .bench_psw_wr, .bench_psw_wdata,
    .push_valid, .push_data, .pc_load, .pc_load_addr, .instr_done,
    .return_from_interrupt_instr, .psw_wr, .psw_wdata, .pc_now,
    .saved_psw, .entries, .vec_taken
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    step(1);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    step(1);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    step(1);
    sfr_addr = a;
    sfr_rd = 1'b1;
    step(1);
    sfr_rd = 1'b0;
    chk(sfr_rdata, e);
  endtask : rd

  task automatic program_status_word(input logic [7:0] v);
    step(1);
    bench_psw_wdata = v;
    bench_psw_wr = 1'b1;
    step(1);
    bench_psw_wr = 1'b0;
  endtask : program_status_word

  // one-cycle event pulses: peripheral requests, watchdog, return
  task automatic ev(input logic [11:0] p, input logic w, input logic r);
    step(1);
    periph_req = p;
    wdt_overflow = w;
    return_from_interrupt_instr_go = r;
    step(1);
    periph_req = 12'h000;
    wdt_overflow = 1'b0;
    return_from_interrupt_instr_go = 1'b0;
  endtask : ev

  task automatic wait_entry(input logic [7:0] n);
    int k;
    k = 0;
    while (entries !== n && k < 300) begin
      step(1);
      k++;
    end
    chk(entries, n);
  endtask : wait_entry

  // run needs a few hundred cycles; the limit of 20000 cycles is ample
  initial begin
    #80000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, bench_psw_wdata} = '0;
    {bench_psw_wr, ext_irq_pin, wdt_overflow, wdt_nmi_mode} = '0;
    {periph_req, cpu_clock_divider_bit, halt, return_from_interrupt_instr_go} = '0;
    gap = 4'h1;
    reset = 1'b1;
    repeat (10) @(posedge mclk);
    #1 reset = 1'b0;
    for (int a = 0; a < 16; a++)
      rd(16'hFFE0 + 16'(a), (a >= 4 && a <= 10 && a != 7) ? 8'hFF : 8'h00);
    chk(psw_out, 8'h02);
    $display("test reset values done");
    wr(16'hFFE6, 8'hFF);
    wr(16'hFFEA, 8'hFF);
    wr(16'hFFE2, 8'h00);
    wr(16'hFFE5, 8'hFE);
    wr(16'hFFE9, 8'hFE);
    program_status_word(8'h82);
    ev(12'h001, 1'b0, 1'b0);
    wait_entry(8'h01);
    chk(vec_taken, 16'h0014);
    chk(saved_psw, 8'h82);
    chk(psw_out, 8'h00);
    rd(16'hFFE1, 8'h00);
    $display("test maskable entry done");
    wr(16'hFFE5, 8'hFC);
    program_status_word(8'h80);
    ev(12'h002, 1'b0, 1'b0);
    step(30);
    chk(entries, 8'h01);
    chk(irq_pending, 1'b0);
    rd(16'hFFE1, 8'h02);
    ev(12'h000, 1'b0, 1'b1);
    wait_entry(8'h02);
    chk(vec_taken, 16'h0016);
    chk(psw_out, 8'h02);
    $display("test priority hold done");
    wr(16'hFFE5, 8'hC3);
    wr(16'hFFE9, 8'hC5);
    ev(12'h00C, 1'b0, 1'b0);
    step(3);
    chk(win_valid, 1'b1);
    chk(win_index, 5'h0B);
    chk(win_vector, 16'h001A);
    wr(16'hFFE1, 8'h00);
    ev(12'h030, 1'b0, 1'b0);
    step(3);
    chk(win_index, 5'h0C);
    chk(entries, 8'h02);
    wr(16'hFFE1, 8'h00);
    $display("test arbitration done");
    for (int i = 0; i < 4; i++) begin
      wr(16'hFFED, {6'h00, CODES[2*i +: 2]});
      step(1);
      ext_irq_pin[3] = 1'b1;
      step(6);
      rd(16'hFFE0, {3'h0, RISE_HIT[i], 4'h0});
      chk(standby_release, 1'b0);
      wr(16'hFFE0, 8'h00);
      ext_irq_pin[3] = 1'b0;
      step(6);
      rd(16'hFFE0, {3'h0, FALL_HIT[i], 4'h0});
      wr(16'hFFE0, 8'h00);
    end
    $display("test edge select done");
    wr(16'hFFEC, 8'h04);
    wr(16'hFFEF, 8'h00);
    ext_irq_pin[0] = 1'b1;
    step(1);
    ext_irq_pin[0] = 1'b0;
    step(6);
    rd(16'hFFE0, 8'h00);
    ext_irq_pin[0] = 1'b1;
    step(8);
    rd(16'hFFE0, 8'h02);
    ext_irq_pin[0] = 1'b0;
    wr(16'hFFE0, 8'h00);
    step(4);
    // the core clock option stops in halt, so a long pulse goes unseen
    halt = 1'b1;
    ext_irq_pin[0] = 1'b1;
    step(10);
    ext_irq_pin[0] = 1'b0;
    step(4);
    halt = 1'b0;
    step(4);
    rd(16'hFFE0, 8'h00);
    // interval mode: the watchdog only raises its flag
    ev(12'h000, 1'b1, 1'b0);
    rd(16'hFFE0, 8'h01);
    wr(16'hFFE0, 8'h00);
    $display("test noise remover done");
    wr(16'hFFE5, 8'hFF);
    wr(16'hFFE8, 8'hFF);
    wdt_nmi_mode = 1'b1;
    gap = 4'h4;
    ev(12'h000, 1'b1, 1'b0);
    wait_entry(8'h03);
    chk(vec_taken, 16'h0004);
    chk(saved_psw, 8'h02);
    chk(psw_out, 8'h00);
    rd(16'hFFE0, 8'h00);
    ev(12'h000, 1'b1, 1'b0);
    step(5);
    ev(12'h000, 1'b1, 1'b0);
    step(40);
    chk(entries, 8'h03);
    ev(12'h000, 1'b0, 1'b1);
    wait_entry(8'h04);
    step(60);
    chk(entries, 8'h04);
    $display("test non-maskable done");
    report_and_stop();
  end
endmodule : vectored_interrupt_controller_bench
`default_nettype wire
